// ### src/elsu_core.sv
// effective-address load and logical shift execution unit
//
// Behaviour
// - load y with address, never indirect
// - address is base plus constant or accumulator
// - pre-modified y base loads modified address
// - post-modified y base loads unmodified address
// - other base: copy to y, then modify
// - load y opcode is 19
// - memory left shift, carry from bit 7
// - accumulator left shift, carry from bit 7
// - double left shift, carry from bit 15
// - n from top, z on zero, v=n^c
// - memory right shift clears n
// - accumulator a right shift, opcode 44
// - memory left shift opcodes 78 and 68
// - memory right shift opcodes 74 and 64
// - memory shift is read, fetch, write
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module elsu_core (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // memory bus
   output logic             mem_cyc_o,
   output logic             mem_we_o,
   output logic             mem_pfetch_o,
   output logic      [15:0] mem_adr_o,
   output logic      [7:0]  mem_dat_o,
   input  wire logic [7:0]  mem_dat_i,
   input  wire logic        mem_ack_i
);
   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  sel);
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // fold shift flags into ccr, upper half untouched
   function automatic logic [7:0] fold_cc(input logic [7:0] cc,
                                          input logic n, input logic z,
                                          input logic v, input logic c);
      fold_cc = cc;
      fold_cc[elsu_pkg::CC_N] = n;
      fold_cc[elsu_pkg::CC_Z] = z;
      fold_cc[elsu_pkg::CC_V] = v;
      fold_cc[elsu_pkg::CC_C] = c;
   endfunction

   logic [7:0]  a_r, b_r, ccr_r, opc_r, idxc_r, ptr_hi_r, res_r;
   logic [15:0] x_r, y_r, sp_r, pc_r, opnd_r, addr_r;
   logic        ack_r, err_r;
   logic [31:0] dat_r, rd_nxt;
   logic [3:0]  flg_r;
   elsu_pkg::elsu_state_e state_r;

   // bus decode: writes land on the edge where ack is seen
   logic        acc_w, wr_w;
   logic [7:0]  ofs_w;
   assign ofs_w = {wb_adr_i[7:2], 2'b00};
   assign acc_w = wb_cyc_i & wb_stb_i;
   assign wr_w  = acc_w & wb_we_i & ack_r & (state_r == elsu_pkg::ST_IDLE);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc_w & ~ack_r;
         if (acc_w & ~ack_r)
            dat_r <= rd_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // unmapped offsets read as zero and ignore writes
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (ofs_w)
         elsu_pkg::OFS_CTRL: begin
            rd_nxt[elsu_pkg::CTRL_BUSY] = state_r != elsu_pkg::ST_IDLE;
            rd_nxt[elsu_pkg::CTRL_ERR]  = err_r;
         end
         elsu_pkg::OFS_OPC:  rd_nxt[7:0]  = opc_r;
         elsu_pkg::OFS_IDXC: rd_nxt[7:0]  = idxc_r;
         elsu_pkg::OFS_OPND: rd_nxt[15:0] = opnd_r;
         elsu_pkg::OFS_ACCA: rd_nxt[7:0]  = a_r;
         elsu_pkg::OFS_ACCB: rd_nxt[7:0]  = b_r;
         elsu_pkg::OFS_IDXX: rd_nxt[15:0] = x_r;
         elsu_pkg::OFS_IDXY: rd_nxt[15:0] = y_r;
         elsu_pkg::OFS_STKP: rd_nxt[15:0] = sp_r;
         elsu_pkg::OFS_PROG: rd_nxt[15:0] = pc_r;
         elsu_pkg::OFS_CCR:  rd_nxt[7:0]  = ccr_r;
         default:            rd_nxt       = 32'h0000_0000;
      endcase
   end

   // opcode decode
   logic is_load_y_effective_address, is_sla, is_slb, is_sld, is_sra, is_mext, is_midx;
   logic is_mleft, is_inh, legal, start;
   assign is_load_y_effective_address  = opc_r == elsu_pkg::OPC_LOAD_Y_EFFECTIVE_ADDRESS;
   assign is_sla   = opc_r == elsu_pkg::OPC_SLA;
   assign is_slb   = opc_r == elsu_pkg::OPC_SLB;
   assign is_sld   = opc_r == elsu_pkg::OPC_SLD;
   assign is_sra   = opc_r == elsu_pkg::OPC_SRA;
   assign is_mext  = (opc_r == elsu_pkg::OPC_SLME)
                   | (opc_r == elsu_pkg::OPC_SRME);
   assign is_midx  = (opc_r == elsu_pkg::OPC_SLMI)
                   | (opc_r == elsu_pkg::OPC_SRMI);
   assign is_mleft = (opc_r == elsu_pkg::OPC_SLME)
                   | (opc_r == elsu_pkg::OPC_SLMI);
   assign is_inh   = is_sla | is_slb | is_sld | is_sra;

   logic [1:0] base_sel, osrc;
   logic [2:0] mode;
   logic       ind, auto_m;
   logic [15:0] amt;
   assign base_sel = idxc_r[elsu_pkg::IDXC_BASE_LO +: 2];
   assign osrc     = idxc_r[elsu_pkg::IDXC_OSRC_LO +: 2];
   assign mode     = idxc_r[elsu_pkg::IDXC_MODE_LO +: 3];
   assign ind      = idxc_r[elsu_pkg::IDXC_IND];
   assign auto_m   = mode != elsu_pkg::MODE_OFS;
   assign amt      = {12'h000, opnd_r[elsu_pkg::AMT_W-1:0]};

   // indirect forms of the address load are refused
   assign legal = is_inh | is_mext | is_midx | (is_load_y_effective_address & ~ind);
   assign start = wr_w & (ofs_w == elsu_pkg::OFS_CTRL) & wb_sel_i[0]
                & wb_dat_i[elsu_pkg::CTRL_GO];

   // effective address from base and offset
   logic [15:0] base_v, off_v, ea, modb;
   always_comb begin
      unique case (base_sel)
         elsu_pkg::BASE_X:  base_v = x_r;
         elsu_pkg::BASE_Y:  base_v = y_r;
         elsu_pkg::BASE_SP: base_v = sp_r;
         default:           base_v = pc_r;
      endcase
      unique case (osrc)
         elsu_pkg::OSRC_A: off_v = {8'h00, a_r};
         elsu_pkg::OSRC_B: off_v = {8'h00, b_r};
         elsu_pkg::OSRC_D: off_v = {a_r, b_r};
         default:          off_v = opnd_r;
      endcase
      modb = base_v;
      ea   = base_v + off_v;
      if (mode == elsu_pkg::MODE_PRI || mode == elsu_pkg::MODE_POI)
         modb = base_v + amt;
      else if (mode == elsu_pkg::MODE_PRD || mode == elsu_pkg::MODE_POD)
         modb = base_v - amt;
      if (mode == elsu_pkg::MODE_PRI || mode == elsu_pkg::MODE_PRD)
         ea = modb;
      else if (auto_m)
         ea = base_v;
   end

   logic go_ok, upd_base;
   assign go_ok    = start & legal;
   assign upd_base = go_ok & auto_m & (is_load_y_effective_address | is_midx);

   // shared shifter: memory byte while reading, else accumulators
   logic [15:0] sh_in, sh_res;
   logic        sh_wide, sh_left, sh_n, sh_z, sh_v, sh_c, mem_rd_done;
   assign mem_rd_done = (state_r == elsu_pkg::ST_RD) & mem_ack_i;
   assign sh_in   = (state_r == elsu_pkg::ST_RD) ? {8'h00, mem_dat_i} :
                    is_sld ? {a_r, b_r} :
                    is_slb ? {8'h00, b_r} : {8'h00, a_r};
   assign sh_wide = (state_r != elsu_pkg::ST_RD) & is_sld;
   assign sh_left = (state_r == elsu_pkg::ST_RD) ? is_mleft : ~is_sra;

   elsu_shift_unit u_shift (
      .opnd_i (sh_in),
      .wide_i (sh_wide),
      .left_i (sh_left),
      .res_o  (sh_res),
      .n_o    (sh_n),
      .z_o    (sh_z),
      .v_o    (sh_v),
      .c_o    (sh_c)
   );

   // command and addressing registers, error set or cleared by every start
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         opc_r  <= 8'h00;
         idxc_r <= 8'h00;
         opnd_r <= 16'h0000;
         err_r  <= 1'b0;
      end else begin
         if (wr_w && ofs_w == elsu_pkg::OFS_OPC && wb_sel_i[0])
            opc_r <= wb_dat_i[7:0];
         if (wr_w && ofs_w == elsu_pkg::OFS_IDXC && wb_sel_i[0])
            idxc_r <= wb_dat_i[7:0];
         if (wr_w && ofs_w == elsu_pkg::OFS_OPND)
            opnd_r <= merge16(opnd_r, wb_dat_i, wb_sel_i);
         if (start)
            err_r <= ~legal;
      end
   end

   // accumulators
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         a_r <= 8'h00;
         b_r <= 8'h00;
      end else begin
         if (wr_w && ofs_w == elsu_pkg::OFS_ACCA && wb_sel_i[0])
            a_r <= wb_dat_i[7:0];
         if (wr_w && ofs_w == elsu_pkg::OFS_ACCB && wb_sel_i[0])
            b_r <= wb_dat_i[7:0];
         if (go_ok && (is_sla || is_sra))
            a_r <= sh_res[7:0];
         if (go_ok && is_slb)
            b_r <= sh_res[7:0];
         if (go_ok && is_sld) begin
            a_r <= sh_res[15:8];
            b_r <= sh_res[7:0];
         end
      end
   end

   // index registers and stack pointer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         x_r  <= 16'h0000;
         y_r  <= 16'h0000;
         sp_r <= 16'h0000;
      end else begin
         if (wr_w && ofs_w == elsu_pkg::OFS_IDXX)
            x_r <= merge16(x_r, wb_dat_i, wb_sel_i);
         if (wr_w && ofs_w == elsu_pkg::OFS_IDXY)
            y_r <= merge16(y_r, wb_dat_i, wb_sel_i);
         if (wr_w && ofs_w == elsu_pkg::OFS_STKP)
            sp_r <= merge16(sp_r, wb_dat_i, wb_sel_i);
         // base register takes its modified value
         if (upd_base && base_sel == elsu_pkg::BASE_X)
            x_r <= modb;
         if (upd_base && base_sel == elsu_pkg::BASE_Y)
            y_r <= modb;
         if (upd_base && base_sel == elsu_pkg::BASE_SP)
            sp_r <= modb;
         // address load wins over the base update of y
         if (go_ok && is_load_y_effective_address)
            y_r <= ea;
      end
   end

   // program counter: bus, pc-based auto mode, program fetch
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         pc_r <= 16'h0000;
      else if (wr_w && ofs_w == elsu_pkg::OFS_PROG)
         pc_r <= merge16(pc_r, wb_dat_i, wb_sel_i);
      else if (upd_base && base_sel == elsu_pkg::BASE_PC)
         pc_r <= modb;
      else if (state_r == elsu_pkg::ST_PF && mem_ack_i)
         pc_r <= pc_r + elsu_pkg::PFETCH_STEP;
   end

   // condition codes: the address load has no branch here
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         ccr_r <= elsu_pkg::CCR_RST;
      else if (wr_w && ofs_w == elsu_pkg::OFS_CCR && wb_sel_i[0])
         ccr_r <= wb_dat_i[7:0];
      // inherent shifts update only n z v c
      else if (go_ok && is_inh)
         ccr_r <= fold_cc(ccr_r, sh_n, sh_z, sh_v, sh_c);
      // memory shift flags land with the write
      else if (state_r == elsu_pkg::ST_WR && mem_ack_i)
         ccr_r <= fold_cc(ccr_r, flg_r[3], flg_r[2], flg_r[1], flg_r[0]);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_r  <= elsu_pkg::ST_IDLE;
         addr_r   <= 16'h0000;
         ptr_hi_r <= 8'h00;
         res_r    <= 8'h00;
         flg_r    <= 4'h0;
      end else begin
         unique case (state_r)
            elsu_pkg::ST_IDLE: begin
               if (go_ok && is_mext) begin
                  addr_r  <= opnd_r;
                  state_r <= elsu_pkg::ST_RD;
               end else if (go_ok && is_midx) begin
                  addr_r  <= ea;
                  state_r <= ind ? elsu_pkg::ST_IHI : elsu_pkg::ST_RD;
               end else if (go_ok && is_load_y_effective_address)
                  state_r <= elsu_pkg::ST_PF;
            end
            elsu_pkg::ST_IHI:
               if (mem_ack_i) begin
                  ptr_hi_r <= mem_dat_i;
                  addr_r   <= addr_r + 16'h0001;
                  state_r  <= elsu_pkg::ST_ILO;
               end
            elsu_pkg::ST_ILO:
               if (mem_ack_i) begin
                  addr_r  <= {ptr_hi_r, mem_dat_i};
                  state_r <= elsu_pkg::ST_RD;
               end
            elsu_pkg::ST_RD:
               // shift the byte as it arrives
               if (mem_rd_done) begin
                  res_r   <= sh_res[7:0];
                  flg_r   <= {sh_n, sh_z, sh_v, sh_c};
                  state_r <= elsu_pkg::ST_PF;
               end
            elsu_pkg::ST_PF:
               if (mem_ack_i)
                  state_r <= is_load_y_effective_address ? elsu_pkg::ST_IDLE : elsu_pkg::ST_WR;
            elsu_pkg::ST_WR:
               if (mem_ack_i)
                  state_r <= elsu_pkg::ST_IDLE;
            default: state_r <= elsu_pkg::ST_IDLE;
         endcase
      end
   end

   // the write goes back to the address that was read
   assign mem_cyc_o    = state_r != elsu_pkg::ST_IDLE;
   assign mem_we_o     = state_r == elsu_pkg::ST_WR;
   assign mem_pfetch_o = state_r == elsu_pkg::ST_PF;
   assign mem_adr_o    = mem_pfetch_o ? pc_r : addr_r;
   assign mem_dat_o    = res_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_load_y_effective_address_ccr_keep: assert property (
      go_ok && is_load_y_effective_address |=> ccr_r == $past(ccr_r))
      else $error("address load changed condition codes");
   a_load_y_effective_address_post_y: assert property (
      go_ok && is_load_y_effective_address && base_sel == elsu_pkg::BASE_Y
      && (mode == elsu_pkg::MODE_POI || mode == elsu_pkg::MODE_POD)
      |=> y_r == $past(y_r))
      else $error("post-modified y did not load unmodified address");
   a_load_y_effective_address_other_base: assert property (
      go_ok && is_load_y_effective_address && base_sel == elsu_pkg::BASE_X
      && mode == elsu_pkg::MODE_POI
      |=> y_r == $past(x_r) && x_r == $past(x_r) + $past(amt))
      else $error("post-increment of other base mishandled");
   a_sla_result: assert property (
      go_ok && is_sla |=> a_r == {$past(a_r[6:0]), 1'b0}
      && ccr_r[elsu_pkg::CC_C] == $past(a_r[7]))
      else $error("accumulator a left shift wrong");
   a_sld_carry: assert property (
      go_ok && is_sld |=> {a_r, b_r} == {$past(a_r[6:0]), $past(b_r), 1'b0}
      && ccr_r[elsu_pkg::CC_C] == $past(a_r[7]))
      else $error("double left shift wrong");
   a_sra_neg: assert property (
      go_ok && is_sra |=> !ccr_r[elsu_pkg::CC_N]
      && ccr_r[elsu_pkg::CC_C] == $past(a_r[0]) && a_r[7] == 1'b0)
      else $error("accumulator a right shift wrong");
   a_shift_vflag: assert property (
      go_ok && is_inh |=> ccr_r[elsu_pkg::CC_V]
      == (ccr_r[elsu_pkg::CC_N] ^ ccr_r[elsu_pkg::CC_C]))
      else $error("overflow is not n xor c");
   a_shift_upper: assert property (
      go_ok && is_inh |=> ccr_r[7:4] == $past(ccr_r[7:4]))
      else $error("shift disturbed upper condition bits");
   a_rmw_order: assert property (
      mem_rd_done |=> mem_pfetch_o && !mem_we_o)
      else $error("read not followed by program fetch");
   a_wr_addr: assert property (
      mem_rd_done ##1 (mem_pfetch_o && mem_ack_i)
      |=> mem_we_o && mem_adr_o == $past(addr_r, 2))
      else $error("write address differs from read address");
   a_ack_once: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held for two cycles");

   c_load_y_effective_address_run:  cover property (go_ok && is_load_y_effective_address ##1 mem_pfetch_o);
   c_mem_shift: cover property (mem_rd_done ##[1:20] mem_we_o && mem_ack_i);
   c_indirect:  cover property (state_r == elsu_pkg::ST_IHI ##[1:20]
                                state_r == elsu_pkg::ST_RD);
   c_refused:   cover property (start && !legal);
endmodule

// ### src/elsu_pkg.sv
// constants for the effective-address load and logical shift unit
package elsu_pkg;
   // wishbone register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OPC  = 8'h04;
   localparam logic [7:0] OFS_IDXC = 8'h08;
   localparam logic [7:0] OFS_OPND = 8'h0c;
   localparam logic [7:0] OFS_ACCA = 8'h10;
   localparam logic [7:0] OFS_ACCB = 8'h14;
   localparam logic [7:0] OFS_IDXX = 8'h18;
   localparam logic [7:0] OFS_IDXY = 8'h1c;
   localparam logic [7:0] OFS_STKP = 8'h20;
   localparam logic [7:0] OFS_PROG = 8'h24;
   localparam logic [7:0] OFS_CCR  = 8'h28;
   // control register bits
   localparam int CTRL_GO   = 0;
   localparam int CTRL_BUSY = 0;
   localparam int CTRL_ERR  = 1;
   // indexed configuration fields
   localparam int IDXC_BASE_LO = 0;
   localparam int IDXC_OSRC_LO = 2;
   localparam int IDXC_MODE_LO = 4;
   localparam int IDXC_IND     = 7;
   localparam int AMT_W        = 4;
   localparam logic [1:0] BASE_X  = 2'h0;
   localparam logic [1:0] BASE_Y  = 2'h1;
   localparam logic [1:0] BASE_SP = 2'h2;
   localparam logic [1:0] BASE_PC = 2'h3;
   localparam logic [1:0] OSRC_K  = 2'h0;
   localparam logic [1:0] OSRC_A  = 2'h1;
   localparam logic [1:0] OSRC_B  = 2'h2;
   localparam logic [1:0] OSRC_D  = 2'h3;
   localparam logic [2:0] MODE_OFS = 3'h0;
   localparam logic [2:0] MODE_PRI = 3'h1;
   localparam logic [2:0] MODE_PRD = 3'h2;
   localparam logic [2:0] MODE_POI = 3'h3;
   localparam logic [2:0] MODE_POD = 3'h4;
   // opcodes
   localparam logic [7:0] OPC_LOAD_Y_EFFECTIVE_ADDRESS = 8'h19;
   localparam logic [7:0] OPC_SLA  = 8'h48;
   localparam logic [7:0] OPC_SLB  = 8'h58;
   localparam logic [7:0] OPC_SLD  = 8'h59;
   localparam logic [7:0] OPC_SRA  = 8'h44;
   localparam logic [7:0] OPC_SLME = 8'h78;
   localparam logic [7:0] OPC_SLMI = 8'h68;
   localparam logic [7:0] OPC_SRME = 8'h74;
   localparam logic [7:0] OPC_SRMI = 8'h64;
   // condition code bit positions
   localparam int CC_N = 3;
   localparam int CC_Z = 2;
   localparam int CC_V = 1;
   localparam int CC_C = 0;
   localparam logic [7:0] CCR_RST = 8'hd0;
   localparam logic [15:0] PFETCH_STEP = 16'h0002;
   // execution sequencer, gray along the read-modify-write path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_IHI  = 3'h1,
      ST_ILO  = 3'h3,
      ST_RD   = 3'h2,
      ST_PF   = 3'h6,
      ST_WR   = 3'h7
   } elsu_state_e;
endpackage

// ### src/elsu_shift_unit.sv
// one-place logical shifter with condition flag results
`timescale 1ns/100ps
module elsu_shift_unit (
   // operand and mode
   input  wire logic [15:0] opnd_i,
   input  wire logic        wide_i,
   input  wire logic        left_i,
   // result and flags
   output logic      [15:0] res_o,
   output logic             n_o,
   output logic             z_o,
   output logic             v_o,
   output logic             c_o
);
   always_comb begin
      res_o = 16'h0000;
      c_o   = 1'b0;
      n_o   = 1'b0;
      if (left_i && wide_i) begin
         res_o = {opnd_i[14:0], 1'b0};
         c_o   = opnd_i[15];
         n_o   = res_o[15];
      end else if (left_i) begin
         res_o = {8'h00, opnd_i[6:0], 1'b0};
         c_o   = opnd_i[7];
         n_o   = res_o[7];
      end else begin
         res_o = {9'h000, opnd_i[7:1]};
         c_o   = opnd_i[0];
         n_o   = 1'b0;
      end
   end

   // zero and overflow from post-shift flags
   assign z_o = wide_i ? (res_o == 16'h0000) : (res_o[7:0] == 8'h00);
   assign v_o = n_o ^ c_o;
endmodule

// ### testbench/ea_load_and_shift_unit_bench.sv
// self-checking bench for the address load and shift unit
`timescale 1ns/100ps
module ea_load_and_shift_unit_bench;
   logic        clk_i     = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        wb_cyc_i  = 1'b0;
   logic        wb_stb_i  = 1'b0;
   logic        wb_we_i   = 1'b0;
   logic [7:0]  wb_adr_i  = 8'h00;
   logic [3:0]  wb_sel_i  = 4'hf;
   logic [31:0] wb_dat_i  = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        mem_cyc_o;
   logic        mem_we_o;
   logic        mem_pfetch_o;
   logic [15:0] mem_adr_o;
   logic [7:0]  mem_dat_o;
   logic [7:0]  mem_dat_i;
   logic        mem_ack_i = 1'b0;
   int          num_errors = 0;
   int          checks_done = 0;
   int          cyc_cnt = 0;
   logic [7:0]  mem [256];
   logic [17:0] log_q [$];
   logic [31:0] rd;

   elsu_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o),
      .mem_we_o(mem_we_o), .mem_pfetch_o(mem_pfetch_o),
      .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o),
      .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // idle data bus toggles so a stale byte is never mistaken for data
   assign mem_dat_i = mem_cyc_o ? mem[mem_adr_o[7:0]] : cyc_cnt[7:0];

   // memory with random stalls, every completed access is logged
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      mem_ack_i <= ($urandom_range(0, 2) != 0);
      if (mem_cyc_o === 1'b1 && mem_ack_i === 1'b1) begin
         log_q.push_back({mem_we_o, mem_pfetch_o, mem_adr_o});
         if (mem_we_o) mem[mem_adr_o[7:0]] <= mem_dat_o;
      end
      if (cyc_cnt == 40000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (i == 50) num_errors++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [31:0] e,
                      input string nm);
      wb(1'b0, adr, 32'h0);
      chk(nm, e, rd);
   endtask

   // start an instruction and poll busy under a bound
   task automatic go(input logic [7:0] op);
      wb(1'b1, elsu_pkg::OFS_OPC, {24'h0, op});
      wb(1'b1, elsu_pkg::OFS_CTRL, 32'h1);
      repeat (60) begin
         wb(1'b0, elsu_pkg::OFS_CTRL, 32'h0);
         if (rd[0] === 1'b0) break;
      end
   endtask

   // one-place shift: result in 23:8, flags in 7:0
   function automatic logic [23:0] shf(input logic [7:0] op,
      input logic [15:0] v, input logic [7:0] cc);
      logic [15:0] r;
      logic        n;
      logic        c;
      case (op)
         8'h59: begin r = v << 1; c = v[15]; n = r[15]; end
         8'h44, 8'h74, 8'h64: begin
            r = {9'h0, v[7:1]}; c = v[0]; n = 1'b0;
         end
         default: begin r = {8'h0, v[6:0], 1'b0}; c = v[7]; n = r[7]; end
      endcase
      return {r, cc[7:4], n, r == 16'h0, n ^ c, c};
   endfunction

   initial begin
      logic [7:0]  ops [4];
      logic [7:0]  crn [3];
      logic [7:0]  op, a, b, cc, m, ad, x;
      logic [15:0] pc, r3 [3], bv, ea, nb, ofs;
      logic [3:0]  amt;
      logic [23:0] e;
      void'($urandom(91));
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      crn = '{8'h80, 8'h01, 8'h00};
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc(elsu_pkg::OFS_CCR, 32'hd0, "ccr after reset");
      rdc(elsu_pkg::OFS_ACCA, 32'h0, "a after reset");
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      rdc(8'h3c, 32'h0, "unmapped read");
      $display("test reset done");
      ops = '{8'h48, 8'h58, 8'h59, 8'h44};
      for (int k = 0; k < 24; k++) begin
         op = ops[k % 4];
         a = (k < 12) ? crn[k / 4] : 8'($urandom);
         b = (k < 12) ? crn[k / 4] : 8'($urandom);
         cc = 8'($urandom);
         wb(1'b1, elsu_pkg::OFS_ACCA, {24'h0, a});
         wb(1'b1, elsu_pkg::OFS_ACCB, {24'h0, b});
         wb(1'b1, elsu_pkg::OFS_CCR, {24'h0, cc});
         go(op);
         e = shf(op, op == 8'h58 ? {8'h0, b} :
                     op == 8'h59 ? {a, b} : {8'h0, a}, cc);
         rdc(elsu_pkg::OFS_ACCA, {24'h0, op == 8'h58 ? a : op == 8'h59 ?
             e[23:16] : e[15:8]}, "acc a");
         rdc(elsu_pkg::OFS_ACCB, {24'h0, (op == 8'h58 || op == 8'h59) ?
             e[15:8] : b}, "acc b");
         rdc(elsu_pkg::OFS_CCR, {24'h0, e[7:0]}, "shift ccr");
      end
      $display("test inherent shifts done");
      ops = '{8'h78, 8'h74, 8'h68, 8'h64};
      for (int k = 0; k < 16; k++) begin
         op = ops[k % 4];
         m = (k < 4) ? 8'h81 : 8'($urandom);
         ad = 8'($urandom_range(8'h40, 8'h7f));
         x = 8'($urandom_range(0, 8'h3f));
         pc = 16'h00c0 + 16'(k);
         cc = 8'($urandom);
         mem[ad] = m;
         wb(1'b1, elsu_pkg::OFS_IDXC, 32'h0);
         wb(1'b1, elsu_pkg::OFS_IDXX, {24'h0, x});
         // extended forms take the address as is, indexed add x to it
         wb(1'b1, elsu_pkg::OFS_OPND, {24'h0, (k % 4 < 2) ? ad : ad - x});
         wb(1'b1, elsu_pkg::OFS_PROG, {16'h0, pc});
         wb(1'b1, elsu_pkg::OFS_CCR, {24'h0, cc});
         log_q.delete();
         go(op);
         e = shf(op, {8'h0, m}, cc);
         chk("memory byte", e[15:8], mem[ad]);
         rdc(elsu_pkg::OFS_CCR, {24'h0, e[7:0]}, "mem ccr");
         rdc(elsu_pkg::OFS_PROG, {16'h0, pc + 16'h2}, "pc");
         chk("access count", 3, log_q.size());
         chk("read access", {16'h0, ad}, log_q[0]);
         chk("fetch access", {14'h1, pc}, log_q[1]);
         chk("write access", {14'h2, 8'h0, ad}, log_q[2]);
      end
      // indirect indexed form: pointer at 0x90 names operand 0x00a5
      mem[8'h90] = 8'h00;
      mem[8'h91] = 8'ha5;
      mem[8'ha5] = 8'h41;
      wb(1'b1, elsu_pkg::OFS_IDXX, 32'h0);
      wb(1'b1, elsu_pkg::OFS_OPND, 32'h90);
      wb(1'b1, elsu_pkg::OFS_IDXC, 32'h80);
      log_q.delete();
      go(8'h68);
      chk("indirect byte", 8'h82, mem[8'ha5]);
      chk("indirect count", 5, log_q.size());
      $display("test memory shifts done");
      for (int bs = 0; bs < 3; bs++) begin
         for (int md = 0; md < 6; md++) begin
            foreach (r3[i]) r3[i] = 16'($urandom);
            a = 8'($urandom);
            b = 8'($urandom);
            cc = 8'($urandom);
            amt = 4'($urandom_range(1, 8));
            ofs = (md == 5) ? {a, b} : 16'($urandom);
            wb(1'b1, elsu_pkg::OFS_IDXX, {16'h0, r3[0]});
            wb(1'b1, elsu_pkg::OFS_IDXY, {16'h0, r3[1]});
            wb(1'b1, elsu_pkg::OFS_STKP, {16'h0, r3[2]});
            wb(1'b1, elsu_pkg::OFS_ACCA, {24'h0, a});
            wb(1'b1, elsu_pkg::OFS_ACCB, {24'h0, b});
            wb(1'b1, elsu_pkg::OFS_CCR, {24'h0, cc});
            wb(1'b1, elsu_pkg::OFS_OPND, {16'h0, md == 0 ? ofs :
               {12'h0, amt}});
            wb(1'b1, elsu_pkg::OFS_IDXC, {25'h0, md == 5 ? 3'h0 : 3'(md),
               md == 5 ? 2'h3 : 2'h0, 2'(bs)});
            go(8'h19);
            bv = r3[bs];
            nb = (md == 1 || md == 3) ? bv + 16'(amt) :
                 (md == 2 || md == 4) ? bv - 16'(amt) : bv;
            ea = (md == 1 || md == 2) ? nb : (md > 2 && md < 5) ? bv :
                 bv + ofs;
            rdc(elsu_pkg::OFS_IDXY, {16'h0, ea}, "y");
            if (bs != 1) rdc(bs == 0 ? elsu_pkg::OFS_IDXX :
               elsu_pkg::OFS_STKP, {16'h0, nb}, "base");
            rdc(elsu_pkg::OFS_CCR, {24'h0, cc}, "lea ccr");
         end
      end
      $display("test address load done");
      wb(1'b1, elsu_pkg::OFS_IDXC, 32'h80);
      go(8'h19);
      chk("indirect err", 1'b1, rd[1]);
      go(8'h00);
      chk("illegal err", 1'b1, rd[1]);
      go(8'h48);
      chk("err cleared", 1'b0, rd[1]);
      $display("test errors done");
      tally_and_finish();
   end
endmodule
